// ### hw/ltc_regs.sv
// Control and status register bank of a 4B3T line transceiver.
// Assumes a classic Wishbone master, synchronous inputs, one clock.
//
// Chosen here: the Wishbone register port.
module ltc_regs #(
	parameter logic [7:0] FW_REV = ltc_pkg::LTC_FW_REV_DEF // Arbitrary value
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          srst,
	// Wishbone slave
	input  wire logic                          wbCyc,
	input  wire logic                          wbStb,
	input  wire logic                          wbWe,
	input  wire logic [ltc_pkg::LTC_ADR_W-1:0] wbAdr,
	input  wire logic [3:0]                    wbSel,
	input  wire logic [ltc_pkg::LTC_DAT_W-1:0] wbDatW,
	output logic      [ltc_pkg::LTC_DAT_W-1:0] wbDatR,
	output logic                               wbAck,
	// State machine side
	input  wire logic [ltc_pkg::LTC_CODE_W-1:0] smIndCode,
	output logic      [ltc_pkg::LTC_CODE_W-1:0] smCmdCode,
	input  wire logic                           codeViolation,
	input  wire logic                           frameStart,
	// System serial interface command channel
	input  wire logic [ltc_pkg::LTC_CODE_W-1:0] sysCmdIn,
	output logic      [ltc_pkg::LTC_CODE_W-1:0] sysIndOut,
	// Channel data from and to the system interface
	input  wire logic [ltc_pkg::LTC_B_W-1:0] sysRxB1,
	input  wire logic [ltc_pkg::LTC_B_W-1:0] sysRxB2,
	input  wire logic [ltc_pkg::LTC_D_W-1:0] sysRxD,
	output logic      [ltc_pkg::LTC_B_W-1:0] sysTxB1,
	output logic      [ltc_pkg::LTC_B_W-1:0] sysTxB2,
	output logic      [ltc_pkg::LTC_D_W-1:0] sysTxD,
	// Channel data from and to the line side
	input  wire logic [ltc_pkg::LTC_B_W-1:0] lineRxB1,
	input  wire logic [ltc_pkg::LTC_B_W-1:0] lineRxB2,
	input  wire logic [ltc_pkg::LTC_D_W-1:0] lineRxD,
	output logic      [ltc_pkg::LTC_B_W-1:0] lineTxB1,
	output logic      [ltc_pkg::LTC_B_W-1:0] lineTxB2,
	output logic      [ltc_pkg::LTC_D_W-1:0] lineTxD,
	// Interrupt
	output logic                             irqOut
);
	import ltc_pkg::*;

	// All state of the block
	typedef struct packed {
		logic                  ack;
		logic [LTC_DAT_W-1:0]  datR;
		logic                  irq;
		logic [LTC_CODE_W-1:0] smCmd;
		logic [LTC_CODE_W-1:0] sysInd;
		logic [LTC_CH_W-1:0]   sysTx;
		logic [LTC_CH_W-1:0]   lineTx;
		logic                  cpuCtl;
		logic [LTC_CODE_W-1:0] codeWr;
		logic [4:0]            loopCtl;
		logic [7:0]            mask;
		logic [7:0]            status;
		logic [LTC_CNT_W-1:0]  errCnt;
		logic [LTC_CODE_W-1:0] prevInd;
	} ltc_state_t;

	ltc_state_t st_r;
	ltc_state_t st_nxt;

	// Channel helpers: packed as {D, B2, B1}
	function automatic logic [LTC_CH_W-1:0] loopOut(
		input logic [LTC_CH_W-1:0] closed,
		input logic [LTC_CH_W-1:0] own,
		input logic [LTC_CH_W-1:0] far
	);
		loopOut = (closed & own) | (~closed & far);
	endfunction

	function automatic logic [LTC_CH_W-1:0] fwdOut(
		input logic [LTC_CH_W-1:0] closed,
		input logic                nonTrans,
		input logic [LTC_CH_W-1:0] src
	);
		fwdOut = nonTrans ? (src | closed) : src;
	endfunction

	// Request decode
	logic                  busReq;
	logic [7:0]            regIdx;
	logic                  wrLow;
	logic                  rdStat;
	logic                  rdCnt;
	logic [LTC_CH_W-1:0]   sysRx;
	logic [LTC_CH_W-1:0]   lineRx;
	logic [LTC_CH_W-1:0]   closedMask;
	logic [7:0]            events;
	logic [7:0]            maskView;

	// New request, taken in the cycle before ack rises
	assign busReq = wbCyc & wbStb & ~st_r.ack;
	assign regIdx = wbAdr[9:2];
	assign wrLow  = busReq & wbWe & wbSel[0];
	assign rdStat = busReq & ~wbWe & (regIdx == LTC_IDX_IRQ_STAT);
	assign rdCnt  = busReq & ~wbWe & (regIdx == LTC_IDX_ERRCNT);

	// Channel bundles
	assign sysRx  = {sysRxD, sysRxB2, sysRxB1};
	assign lineRx = {lineRxD, lineRxB2, lineRxB1};

	// Which channel bits are looped
	always_comb begin
		closedMask = '0;
		if (st_r.loopCtl[LTC_LP_FULL_BIT]) begin
			closedMask = '1;
		end
		if (st_r.loopCtl[LTC_LP_B2_BIT]) begin
			closedMask[15:8] = '1;
		end
		if (st_r.loopCtl[LTC_LP_B1_BIT]) begin
			closedMask[7:0] = '1;
		end
	end

	// Event sources for the status flags
	always_comb begin
		events = '0;
		events[LTC_IRQ_CODE_BIT]  = smIndCode != st_r.prevInd;
		events[LTC_IRQ_VIOL_BIT]  = codeViolation;
		events[LTC_IRQ_FRAME_BIT] = frameStart;
	end

	// Mask as seen by software, unused bits as ones
	assign maskView = st_r.mask | ~LTC_IRQ_USED;

	// Next state
	always_comb begin
		st_nxt = st_r;

		// One-cycle ack per request; unmapped reads give zero
		st_nxt.ack = busReq;
		if (busReq && !wbWe) begin
			st_nxt.datR = '0;
			unique case (regIdx)
				LTC_IDX_OPERATION_MODE: begin
					st_nxt.datR[LTC_OP_CPU_BIT] = st_r.cpuCtl;
				end
				LTC_IDX_CODE_RD: begin
					st_nxt.datR[3:0] = smIndCode;
				end
				LTC_IDX_LOOP: begin
					st_nxt.datR[4:0] = st_r.loopCtl;
				end
				LTC_IDX_ERRCNT: begin
					st_nxt.datR[7:0] = st_r.errCnt;
				end
				LTC_IDX_IRQ_STAT: begin
					st_nxt.datR[7:0] = st_r.status;
				end
				LTC_IDX_IRQ_MASK: begin
					st_nxt.datR[7:0] = maskView;
				end
				LTC_IDX_FW_REV: begin
					st_nxt.datR[7:0] = FW_REV;
				end
				default: begin
					st_nxt.datR = '0;
				end
			endcase
		end

		// Register writes, low byte lane only
		if (wrLow) begin
			unique case (regIdx)
				LTC_IDX_OPERATION_MODE: begin
					st_nxt.cpuCtl = wbDatW[LTC_OP_CPU_BIT];
				end
				LTC_IDX_CODE_WR: begin
					st_nxt.codeWr = wbDatW[3:0];
				end
				LTC_IDX_LOOP: begin
					st_nxt.loopCtl = wbDatW[4:0];
				end
				LTC_IDX_IRQ_MASK: begin
					st_nxt.mask = wbDatW[7:0] | ~LTC_IRQ_USED;
				end
				default: begin
					st_nxt.mask = st_r.mask;
				end
			endcase
		end

		// Sticky flags: read clears, a new event wins
		st_nxt.status = (rdStat ? 8'h00 : st_r.status) | events;
		st_nxt.prevInd = smIndCode;

		// Saturating error counter; its read reloads it with one for a violation in that cycle, else zero
		if (rdCnt) begin
			st_nxt.errCnt = {7'h00, codeViolation};
		end else if (codeViolation && st_r.errCnt != LTC_CNT_MAX) begin
			st_nxt.errCnt = st_r.errCnt + 8'h01;
		end

		// Level interrupt from unmasked flags
		st_nxt.irq = |(st_r.status & ~st_r.mask);

		// Code routing by the control bit
		if (st_r.cpuCtl) begin
			st_nxt.smCmd  = st_r.codeWr;
			st_nxt.sysInd = LTC_CODE_IDLE;
		end else begin
			st_nxt.smCmd  = sysCmdIn;
			st_nxt.sysInd = smIndCode;
		end

		// Loop paths, one direction for all loops
		if (!st_r.loopCtl[LTC_LP_DIR_BIT]) begin
			st_nxt.sysTx  = loopOut(closedMask, sysRx, lineRx);
			st_nxt.lineTx = fwdOut(closedMask, st_r.loopCtl[LTC_LP_PASS_THROUGH_SELECT_BIT], sysRx);
		end else begin
			st_nxt.lineTx = loopOut(closedMask, lineRx, sysRx);
			st_nxt.sysTx  = fwdOut(closedMask, st_r.loopCtl[LTC_LP_PASS_THROUGH_SELECT_BIT], lineRx);
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clock) begin
		if (srst) begin
			st_r.ack     <= 1'b0;
			st_r.datR    <= '0;
			st_r.irq     <= 1'b0;
			st_r.smCmd   <= LTC_CODE_WR_RST;
			st_r.sysInd  <= '0;
			st_r.sysTx   <= '0;
			st_r.lineTx  <= '0;
			st_r.cpuCtl  <= LTC_OPERATION_MODE_RST[LTC_OP_CPU_BIT];
			st_r.codeWr  <= LTC_CODE_WR_RST;
			st_r.loopCtl <= LTC_LOOP_RST;
			st_r.mask    <= LTC_MASK_RST;
			st_r.status  <= '0;
			st_r.errCnt  <= '0;
			st_r.prevInd <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign wbAck     = st_r.ack;
	assign wbDatR    = st_r.datR;
	assign irqOut    = st_r.irq;
	assign smCmdCode = st_r.smCmd;
	assign sysIndOut = st_r.sysInd;
	assign sysTxB1   = st_r.sysTx[7:0];
	assign sysTxB2   = st_r.sysTx[15:8];
	assign sysTxD    = st_r.sysTx[17:16];
	assign lineTxB1  = st_r.lineTx[7:0];
	assign lineTxB2  = st_r.lineTx[15:8];
	assign lineTxD   = st_r.lineTx[17:16];

	// Checks on the registered behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_SYS_ROUTE: assert property (
		!st_r.cpuCtl && !$past(srst) |=> smCmdCode == $past(sysCmdIn) && sysIndOut == $past(smIndCode)
	) else $error("codes not routed to system port");

	AST_CPU_IDLE: assert property (
		st_r.cpuCtl |=> sysIndOut == 4'hF && smCmdCode == $past(st_r.codeWr)
	) else $error("command channel not idle under processor control");

	AST_READBACK: assert property (
		busReq && !wbWe && regIdx == LTC_IDX_CODE_RD |=> wbAck && wbDatR == {28'h0, $past(smIndCode)}
	) else $error("readback value wrong");

	AST_CODE_FLAG: assert property (
		smIndCode != st_r.prevInd |=> st_r.status[LTC_IRQ_CODE_BIT]
	) else $error("code change flag not set");

	AST_FRAME_FLAG: assert property (
		frameStart |=> st_r.status[LTC_IRQ_FRAME_BIT] ##1 (irqOut || $past(st_r.mask[LTC_IRQ_FRAME_BIT]))
	) else $error("frame flag or interrupt missing");

	AST_IRQ_LEVEL: assert property (
		##1 irqOut == |($past(st_r.status) & ~$past(st_r.mask))
	) else $error("interrupt level wrong");

	AST_MASK_ONES: assert property (
		(st_r.mask | LTC_IRQ_USED) == 8'hFF
	) else $error("unused mask bits not one");

	AST_READ_CLEAR: assert property (
		rdStat && events == 8'h00 |=> st_r.status == 8'h00
	) else $error("status not cleared by read");

	AST_CNT_SAT: assert property (
		st_r.errCnt == 8'hFF && !rdCnt |=> st_r.errCnt == 8'hFF
	) else $error("error counter wrapped");

	AST_NONTRANS: assert property (
		st_r.loopCtl[LTC_LP_FULL_BIT] && st_r.loopCtl[LTC_LP_PASS_THROUGH_SELECT_BIT] && !st_r.loopCtl[LTC_LP_DIR_BIT]
		|=> lineTxB1 == 8'hFF && lineTxB2 == 8'hFF && lineTxD == 2'h3
	) else $error("forwarded data not idle ones");

	AST_LOOP_SYS: assert property (
		st_r.loopCtl[LTC_LP_B1_BIT] && !st_r.loopCtl[LTC_LP_DIR_BIT] |=> sysTxB1 == $past(sysRxB1)
	) else $error("B1 loop not closed towards system");

	AST_LOOP_LINE: assert property (
		st_r.loopCtl[LTC_LP_B1_BIT] && st_r.loopCtl[LTC_LP_DIR_BIT] |=> lineTxB1 == $past(lineRxB1)
	) else $error("B1 loop not closed towards line");

	AST_FULL_LOOP: assert property (
		st_r.loopCtl[LTC_LP_FULL_BIT] && !st_r.loopCtl[LTC_LP_DIR_BIT]
		|=> sysTxB1 == $past(sysRxB1) && sysTxB2 == $past(sysRxB2) && sysTxD == $past(sysRxD)
	) else $error("full loop not closed");

	AST_LOOP_OPEN: assert property (
		!st_r.loopCtl[LTC_LP_FULL_BIT] && !st_r.loopCtl[LTC_LP_B2_BIT] && !st_r.loopCtl[LTC_LP_B1_BIT]
		|=> sysTxB1 == $past(lineRxB1) && lineTxB1 == $past(sysRxB1)
	) else $error("open loops do not pass data through");

	AST_B2_ONLY: assert property (
		st_r.loopCtl[LTC_LP_B2_BIT] && !st_r.loopCtl[LTC_LP_FULL_BIT]
		&& !st_r.loopCtl[LTC_LP_B1_BIT] && st_r.loopCtl[LTC_LP_DIR_BIT]
		|=> lineTxB2 == $past(lineRxB2) && lineTxB1 == $past(sysRxB1)
	) else $error("B2 loop not independent of B1");

	AST_PASS_THROUGH_SELECT_FWD: assert property (
		!st_r.loopCtl[LTC_LP_PASS_THROUGH_SELECT_BIT] && !st_r.loopCtl[LTC_LP_DIR_BIT]
		|=> lineTxB1 == $past(sysRxB1) && lineTxB2 == $past(sysRxB2) && lineTxD == $past(sysRxD)
	) else $error("transparent loop not forwarding");

	AST_NONTRANS_SYS: assert property (
		st_r.loopCtl[LTC_LP_B2_BIT] && st_r.loopCtl[LTC_LP_PASS_THROUGH_SELECT_BIT] && st_r.loopCtl[LTC_LP_DIR_BIT]
		|=> sysTxB2 == 8'hFF
	) else $error("forwarded system slot not idle ones");

	AST_CNT_INC: assert property (
		codeViolation && !rdCnt && st_r.errCnt != LTC_CNT_MAX |=> st_r.errCnt == $past(st_r.errCnt) + 8'h01
	) else $error("error counter did not count");

	AST_VIOL_FLAG: assert property (
		codeViolation |=> st_r.status[LTC_IRQ_VIOL_BIT]
	) else $error("violation flag not set");

	AST_IRQ_MASKED: assert property (
		(st_r.status & ~st_r.mask) == 8'h00 |=> !irqOut
	) else $error("interrupt high with no unmasked flag");

	AST_FW_READ: assert property (
		busReq && !wbWe && regIdx == LTC_IDX_FW_REV |=> wbDatR == {24'h0, FW_REV}
	) else $error("firmware revision read wrong");

	AST_ERR_READ: assert property (
		rdCnt |=> wbDatR == {24'h0, $past(st_r.errCnt)}
	) else $error("error counter read wrong");

	AST_STAT_UNUSED: assert property (
		(st_r.status & ~LTC_IRQ_USED) == 8'h00
	) else $error("unused status bit set");

	AST_STAT_READ: assert property (
		rdStat |=> wbDatR == {24'h0, $past(st_r.status)}
	) else $error("status read value wrong");

endmodule // ltc_regs

// ### hw/ltc_pkg.sv
// Constants for the line transceiver control register bank.
// Assumes a classic Wishbone slave, 32-bit data, one clock.
package ltc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] LTC_IDX_OPERATION_MODE   = 8'h60;
	localparam logic [7:0] LTC_IDX_CODE_RD  = 8'h6D;
	localparam logic [7:0] LTC_IDX_CODE_WR  = 8'h6E;
	localparam logic [7:0] LTC_IDX_LOOP     = 8'h70;
	localparam logic [7:0] LTC_IDX_ERRCNT   = 8'h72;
	localparam logic [7:0] LTC_IDX_IRQ_STAT = 8'h7A;
	localparam logic [7:0] LTC_IDX_IRQ_MASK = 8'h7B;
	localparam logic [7:0] LTC_IDX_FW_REV   = 8'h7D;

	// Bus geometry
	localparam int LTC_ADR_W = 10;
	localparam int LTC_DAT_W = 32;

	// Operation mode fields
	localparam int LTC_OP_CPU_BIT = 6;
	localparam logic [7:0] LTC_OPERATION_MODE_RST = 8'h00;

	// Code registers
	localparam int LTC_CODE_W = 4;
	localparam logic [3:0] LTC_CODE_WR_RST = 4'h1;
	localparam logic [3:0] LTC_CODE_IDLE   = 4'hF;

	// Loopback control fields
	localparam int LTC_LP_B1_BIT    = 0;
	localparam int LTC_LP_B2_BIT    = 1;
	localparam int LTC_LP_FULL_BIT  = 2;
	localparam int LTC_LP_PASS_THROUGH_SELECT_BIT = 3;
	localparam int LTC_LP_DIR_BIT   = 4;
	localparam logic [4:0] LTC_LOOP_RST = 5'h08;

	// Interrupt status and mask fields
	localparam int LTC_IRQ_CODE_BIT  = 6;
	localparam int LTC_IRQ_VIOL_BIT  = 5;
	localparam int LTC_IRQ_FRAME_BIT = 0;
	localparam logic [7:0] LTC_IRQ_USED = 8'h61;
	localparam logic [7:0] LTC_MASK_RST = 8'hFF;

	// Counter and channel widths
	localparam int LTC_CNT_W = 8;
	localparam logic [7:0] LTC_CNT_MAX = 8'hFF;
	localparam int LTC_B_W = 8;
	localparam int LTC_D_W = 2;
	localparam int LTC_CH_W = 18;

	// Firmware revision; value is arbitrary
	localparam logic [7:0] LTC_FW_REV_DEF = 8'h5A;

endpackage : ltc_pkg

// ### verification/ltc_sm_model.sv
// Behavioural state machine beside the register bank.
// Assumes one clock shared with ltc_regs and a synchronous reset.
module ltc_sm_model #(
	parameter int FRAME_LEN = 32 // Short frame for a quick run
) (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           srst,
	// Register bank side
	input  wire logic [ltc_pkg::LTC_CODE_W-1:0] smCmdCode,
	output logic      [ltc_pkg::LTC_CODE_W-1:0] smIndCode,
	output logic                                codeViolation,
	output logic                                frameStart,
	// Bench request for violations
	input  wire logic                           violReq
);
	import ltc_pkg::*;
	logic [7:0] frameCnt_r;
	// Indication echoes the command; frames tick free-running
	always_ff @(posedge clock) begin
		if (srst) begin
			smIndCode <= 4'h0;
			frameCnt_r <= 8'h00;
			frameStart <= 1'b0;
			codeViolation <= 1'b0;
		end else begin
			smIndCode <= smCmdCode;
			frameCnt_r <= (frameCnt_r == 8'(FRAME_LEN - 1)) ? 8'h00 : frameCnt_r + 8'h01;
			frameStart <= (frameCnt_r == 8'h00);
			codeViolation <= violReq;
		end
	end
endmodule // ltc_sm_model

// ### verification/ltc_regs_tb_top.sv
// Self-checking bench for the line transceiver register bank.
// Assumes ltc_pkg, ltc_regs and ltc_sm_model compiled before it.
module ltc_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ltc_pkg::*;
	logic clock = 1'b0, srst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, violReq = 1'b0;
	logic [LTC_ADR_W-1:0] wbAdr = 10'h000;
	logic [3:0] wbSel = 4'h0, sysCmdIn = 4'h0, smCmdCode, sysIndOut, smIndCode;
	logic [LTC_DAT_W-1:0] wbDatW = 32'h0, wbDatR, q;
	logic [7:0] sysRxB1 = 8'hA1, sysRxB2 = 8'hB2, lineRxB1 = 8'hC3, lineRxB2 = 8'hD4;
	logic [7:0] sysTxB1, sysTxB2, lineTxB1, lineTxB2;
	logic [1:0] sysRxD = 2'h1, lineRxD = 2'h2, sysTxD, lineTxD;
	logic wbAck, irqOut, codeViolation, frameStart;
	int fail_count = 0;
	int total_checks = 0;
	// Stand-in transparent request code; value is arbitrary
	localparam logic [3:0] XPARENT_REQ = 4'hC;
	ltc_regs dut (
		.clock(clock), .srst(srst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
		.smIndCode(smIndCode), .smCmdCode(smCmdCode), .codeViolation(codeViolation), .frameStart(frameStart),
		.sysCmdIn(sysCmdIn), .sysIndOut(sysIndOut),
		.sysRxB1(sysRxB1), .sysRxB2(sysRxB2), .sysRxD(sysRxD),
		.sysTxB1(sysTxB1), .sysTxB2(sysTxB2), .sysTxD(sysTxD),
		.lineRxB1(lineRxB1), .lineRxB2(lineRxB2), .lineRxD(lineRxD),
		.lineTxB1(lineTxB1), .lineTxB2(lineTxB2), .lineTxD(lineTxD),
		.irqOut(irqOut)
	);
	ltc_sm_model model (
		.clock(clock), .srst(srst), .smCmdCode(smCmdCode), .smIndCode(smIndCode),
		.codeViolation(codeViolation), .frameStart(frameStart), .violReq(violReq)
	);
	// Clock at 250 MHz
	initial forever #2 clock = ~clock;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One classic Wishbone cycle; read data lands in q
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'h0};
		wbSel <= 4'hF;
		wbDatW <= {24'h0, d};
		// Wait for ack; only the watchdog ends a hung wait
		do begin
			@(posedge clock);
		end while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 8'h00);
		chk(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic t_reset;
		logic [7:0] ix [7] = '{LTC_IDX_OPERATION_MODE, LTC_IDX_LOOP, LTC_IDX_ERRCNT, LTC_IDX_IRQ_MASK,
			LTC_IDX_FW_REV, LTC_IDX_CODE_WR, 8'h61};
		logic [7:0] ev [7] = '{8'h00, 8'h08, 8'h00, 8'hFF, LTC_FW_REV_DEF, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) rd(ix[i], {24'h0, ev[i]});
		wb(1'b1, 8'h61, 8'hFF);
		rd(8'h61, 32'h0);
		wb(1'b1, LTC_IDX_FW_REV, 8'h00);
		rd(LTC_IDX_FW_REV, {24'h0, LTC_FW_REV_DEF});
	endtask
	task automatic t_codes;
		sysCmdIn <= 4'h9;
		tick(4);
		chk({28'h0, smCmdCode}, 32'h9);
		chk({28'h0, sysIndOut}, 32'h9);
		rd(LTC_IDX_CODE_RD, 32'h9);
		wb(1'b0, LTC_IDX_IRQ_STAT, 8'h00);
		chk(q & 32'h40, 32'h40);
		wb(1'b1, LTC_IDX_OPERATION_MODE, 8'h40);
		rd(LTC_IDX_OPERATION_MODE, 32'h40);
		wb(1'b1, LTC_IDX_CODE_WR, 8'h07);
		tick(4);
		chk({28'h0, sysIndOut}, 32'hF);
		chk({28'h0, smCmdCode}, 32'h7);
		rd(LTC_IDX_CODE_RD, 32'h7);
		wb(1'b0, LTC_IDX_IRQ_STAT, 8'h00);
		chk(q & 32'h40, 32'h40);
		wb(1'b1, LTC_IDX_OPERATION_MODE, 8'h00);
	endtask
	task automatic t_loops;
		logic [4:0] lv [6] = '{5'h04, 5'h0C, 5'h11, 5'h1A, 5'h03, 5'h08};
		logic [17:0] s, ln, cl, fw, es, el;
		logic d;
		s = {sysRxB1, sysRxB2, sysRxD};
		ln = {lineRxB1, lineRxB2, lineRxD};
		// Bring the state machine to transparent before looping
		sysCmdIn <= XPARENT_REQ;
		tick(4);
		chk({28'h0, smIndCode}, {28'h0, XPARENT_REQ});
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, LTC_IDX_LOOP, {3'h0, lv[i]});
			rd(LTC_IDX_LOOP, {27'h0, lv[i]});
			d = lv[i][4];
			cl = (lv[i][2] ? 18'h3FFFF : 18'h0) | {lv[i][0] ? 8'hFF : 8'h00, lv[i][1] ? 8'hFF : 8'h00, 2'h0};
			fw = lv[i][3] ? 18'h3FFFF : (d ? ln : s);
			es = (~cl & ln) | (cl & (d ? fw : s));
			el = (~cl & s) | (cl & (d ? ln : fw));
			tick(3);
			chk({14'h0, sysTxB1, sysTxB2, sysTxD}, {14'h0, es});
			chk({14'h0, lineTxB1, lineTxB2, lineTxD}, {14'h0, el});
		end
	endtask
	task automatic t_irq;
		wb(1'b0, LTC_IDX_IRQ_STAT, 8'h00);
		rd(LTC_IDX_ERRCNT, 32'h0);
		wb(1'b1, LTC_IDX_IRQ_MASK, 8'hDF);
		tick(2);
		chk({31'h0, irqOut}, 32'h0);
		violReq <= 1'b1;
		tick(3);
		violReq <= 1'b0;
		tick(4);
		chk({31'h0, irqOut}, 32'h1);
		wb(1'b0, LTC_IDX_IRQ_STAT, 8'h00);
		chk(q & 32'h20, 32'h20);
		tick(3);
		chk({31'h0, irqOut}, 32'h0);
		rd(LTC_IDX_ERRCNT, 32'h3);
		wb(1'b1, LTC_IDX_IRQ_MASK, 8'hFE);
		tick(40);
		chk({31'h0, irqOut}, 32'h1);
		wb(1'b0, LTC_IDX_IRQ_STAT, 8'h00);
		chk(q & 32'h1, 32'h1);
		wb(1'b1, LTC_IDX_IRQ_MASK, 8'h00);
		rd(LTC_IDX_IRQ_MASK, 32'h9E);
		wb(1'b1, LTC_IDX_IRQ_MASK, 8'hFF);
		tick(2);
		chk({31'h0, irqOut}, 32'h0);
		// Long violation burst drives the counter into saturation
		violReq <= 1'b1;
		tick(260);
		violReq <= 1'b0;
		tick(2);
		rd(LTC_IDX_ERRCNT, 32'hFF);
	endtask
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		t_reset;
		t_codes;
		t_loops;
		t_irq;
		conclude;
	end
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		conclude;
	end
endmodule // ltc_regs_tb_top
